/* logic/lse_pkg.sv */
// package for the link status and error insertion block
package lse_pkg;
	localparam int LANES = 4;
	localparam logic [11:0] ADDR_FAULT = 12'h308;
	localparam logic [11:0] ADDR_LOCK = 12'h321;
	localparam logic [11:0] ADDR_FRMERR = 12'h323;
	localparam logic [11:0] ADDR_FRMCLR = 12'h324;
	localparam logic [11:0] ADDR_ALIGN = 12'h326;
	localparam logic [11:0] ADDR_FLAGSEL = 12'h330;
	localparam logic [11:0] ADDR_FLAGS = 12'h331;
	localparam logic [11:0] ADDR_CTRL = 12'h332;
	localparam logic [11:0] ADDR_IRQSTAT = 12'h340;
	localparam logic [11:0] ADDR_IRQCLR = 12'h341;
	localparam logic [11:0] ADDR_IRQEN = 12'h342;
	localparam int BIT_LOCALFAULT = 0;
	localparam int BIT_ALIGNED = 0;
	localparam int BIT_FAULTGEN = 0;
	localparam logic CTRL_RESET = 1'h1;
	localparam int IRQ_W = 4;
	localparam int IRQ_LOS = 0;
	localparam int IRQ_RXFULL = 1;
	localparam int IRQ_CRC = 2;
	localparam int IRQ_FCS = 3;
	localparam int RESET_NS = 40;
	localparam int CLK_NS = 5;
	localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] ERR_CHAR = 8'hfe;
	localparam logic [1:0] CTRL_SYNC = 2'h1;
	localparam logic [7:0] ERR_BTYPE = 8'h1e;
	localparam logic [65:0] ERR_BLOCK = {{8{ERR_CHAR[6:0]}}, ERR_BTYPE, CTRL_SYNC};
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} lse_bus_s;
	typedef struct packed {
		logic [65:0] block;
		logic valid;
		logic lastBeat;
		logic abortReq;
	} lse_tx_s;
endpackage : lse_pkg

/* logic/lse_link_status.sv */
// link status registers, loss-of-signal handling and transmit error insertion
`timescale 1ns/100ps
module lse_link_status (
	input wire logic clk,
	input wire logic rst,
	input wire lse_pkg::lse_bus_s bus,
	output logic [31:0] rdata,
	input wire logic [lse_pkg::LANES-1:0] laneWordLock,
	input wire logic [lse_pkg::LANES-1:0] laneClockLock,
	input wire logic alignLock,
	input wire logic signalLoss,
	input wire logic [7:0] txFifoFlags,
	input wire logic [7:0] rxFifoFlags,
	input wire logic rxCrcBad,
	input wire logic rxPayloadBad,
	input wire logic rxDecodeBad,
	input wire lse_pkg::lse_tx_s txIn,
	output lse_pkg::lse_tx_s txOut,
	output logic rxPcsReady,
	output logic localFaultStatus,
	output logic softRxReset,
	output logic crcErrorOut,
	output logic fcsErrorOut,
	output logic decodeErrorOut,
	output logic irq
);
	typedef struct packed {
		logic [31:0] rdata;
		logic [31:0] frmErr;
		logic frmClr;
		logic [7:0] flagSel;
		logic faultGen;
		logic [lse_pkg::IRQ_W-1:0] irqStat;
		logic [lse_pkg::IRQ_W-1:0] irqEn;
		logic rxReady;
		logic localFault;
		logic [3:0] rstCnt;
		logic prevLoss;
		lse_pkg::lse_tx_s tx;
		logic crcErr;
		logic fcsErr;
		logic decErr;
	} lse_state_s;

	lse_state_s q;
	lse_state_s d;
	logic [7:0] flagView;
	logic lossRise;

	// pick flags for the selected fifo; select bit 0 picks transmit flags, else receive flags
	function automatic logic [7:0] flagPick(input logic [7:0] sel, input logic [7:0] tf, input logic [7:0] rf);
		logic [7:0] r;
		r = 8'h00;
		if (sel[0]) begin
			r = tf;
		end else begin
			r = rf;
		end
		return r;
	endfunction : flagPick

	assign flagView = flagPick(q.flagSel, txFifoFlags, rxFifoFlags);
	assign lossRise = signalLoss & ~q.prevLoss;

	// next state
	always_comb begin
		d = q;
		d.prevLoss = signalLoss;
		if (q.frmClr) begin
			d.frmErr = 32'h0;
		end else if (~&laneWordLock && q.frmErr != 32'hffffffff) begin
			d.frmErr = q.frmErr + 32'h1;
		end
		d.rxReady = alignLock & ~signalLoss & (q.rstCnt == 4'h0);
		// local fault from loss of signal
		d.localFault = q.faultGen & signalLoss;
		if (lossRise) begin
			d.rstCnt = 4'(lse_pkg::RESET_CYC);
		end else if (q.rstCnt != 4'h0) begin
			d.rstCnt = q.rstCnt - 4'h1;
		end
		d.tx = txIn;
		// error block replaces data on flagged last beat
		if (txIn.valid && txIn.lastBeat && txIn.abortReq) begin
			d.tx.block = lse_pkg::ERR_BLOCK;
		end
		d.crcErr = rxCrcBad & q.rxReady;
		d.fcsErr = rxPayloadBad & q.rxReady;
		d.decErr = rxDecodeBad & q.rxReady;
		// irq events; set wins over clear
		if (bus.wr && bus.addr == lse_pkg::ADDR_IRQCLR) begin
			d.irqStat = q.irqStat & ~bus.wdata[lse_pkg::IRQ_W-1:0];
		end
		d.irqStat[lse_pkg::IRQ_LOS] = d.irqStat[lse_pkg::IRQ_LOS] | lossRise;
		// receive fifo full is an error event
		d.irqStat[lse_pkg::IRQ_RXFULL] = d.irqStat[lse_pkg::IRQ_RXFULL] | rxFifoFlags[0];
		d.irqStat[lse_pkg::IRQ_CRC] = d.irqStat[lse_pkg::IRQ_CRC] | d.crcErr;
		d.irqStat[lse_pkg::IRQ_FCS] = d.irqStat[lse_pkg::IRQ_FCS] | d.fcsErr;
		// register writes
		if (bus.wr) begin
			if (bus.addr == lse_pkg::ADDR_FRMCLR) begin
				d.frmClr = bus.wdata[0];
			end else if (bus.addr == lse_pkg::ADDR_FLAGSEL) begin
				d.flagSel = bus.wdata[7:0];
			end else if (bus.addr == lse_pkg::ADDR_CTRL) begin
				d.faultGen = bus.wdata[lse_pkg::BIT_FAULTGEN];
			end else if (bus.addr == lse_pkg::ADDR_IRQEN) begin
				d.irqEn = bus.wdata[lse_pkg::IRQ_W-1:0];
			end
		end
		// register reads, answer in next cycle
		d.rdata = 32'h0;
		if (bus.rd) begin
			if (bus.addr == lse_pkg::ADDR_FAULT) begin
				d.rdata[lse_pkg::BIT_LOCALFAULT] = q.localFault;
			end else if (bus.addr == lse_pkg::ADDR_LOCK) begin
				d.rdata[lse_pkg::LANES-1:0] = laneClockLock;
			end else if (bus.addr == lse_pkg::ADDR_FRMERR) begin
				d.rdata = q.frmErr;
			end else if (bus.addr == lse_pkg::ADDR_FRMCLR) begin
				d.rdata[0] = q.frmClr;
			end else if (bus.addr == lse_pkg::ADDR_ALIGN) begin
				d.rdata[lse_pkg::BIT_ALIGNED] = q.rxReady;
			end else if (bus.addr == lse_pkg::ADDR_FLAGSEL) begin
				d.rdata[7:0] = q.flagSel;
			end else if (bus.addr == lse_pkg::ADDR_FLAGS) begin
				d.rdata[7:0] = flagView;
			end else if (bus.addr == lse_pkg::ADDR_CTRL) begin
				d.rdata[0] = q.faultGen;
			end else if (bus.addr == lse_pkg::ADDR_IRQSTAT) begin
				d.rdata[lse_pkg::IRQ_W-1:0] = q.irqStat;
			end else if (bus.addr == lse_pkg::ADDR_IRQEN) begin
				d.rdata[lse_pkg::IRQ_W-1:0] = q.irqEn;
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.faultGen <= lse_pkg::CTRL_RESET;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign txOut = q.tx;
	assign rxPcsReady = q.rxReady;
	assign localFaultStatus = q.localFault;
	assign softRxReset = (q.rstCnt != 4'h0);
	assign crcErrorOut = q.crcErr;
	assign fcsErrorOut = q.fcsErr;
	assign decodeErrorOut = q.decErr;
	assign irq = |(q.irqStat & q.irqEn);

	ready_drop_a: assert property (@(posedge clk) disable iff (rst) signalLoss |=> !rxPcsReady)
		else $error("ready stayed high after loss");
	align_read_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_ALIGN |=> rdata[0] == $past(rxPcsReady))
		else $error("align bit mismatch");
	fault_set_a: assert property (@(posedge clk) disable iff (rst)
		signalLoss && q.faultGen |=> localFaultStatus)
		else $error("local fault not set");
	fault_read_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_FAULT |=> rdata[0] == $past(localFaultStatus))
		else $error("fault bit mismatch");
	rx_reset_a: assert property (@(posedge clk) disable iff (rst)
		$rose(signalLoss) |=> softRxReset [*8])
		else $error("soft reset too short");
	err_block_a: assert property (@(posedge clk) disable iff (rst)
		txIn.valid && txIn.lastBeat && txIn.abortReq |=> txOut.block == lse_pkg::ERR_BLOCK)
		else $error("error block missing");
	tx_pass_a: assert property (@(posedge clk) disable iff (rst)
		signalLoss && !txIn.abortReq |=> txOut == $past(txIn))
		else $error("tx altered by loss");
	// cleared accumulator stays zero under lock
	frm_zero_a: assert property (@(posedge clk) disable iff (rst)
		q.frmClr ##1 (!q.frmClr && &laneWordLock) |=> q.frmErr == 32'h0)
		else $error("framing count nonzero");
	flag_sel_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_FLAGS |=> rdata[7:0] == $past(flagView))
		else $error("flag view mismatch");

	ready_align_a: assert property (@(posedge clk) disable iff (rst)
		!alignLock |=> !rxPcsReady)
		else $error("ready high without alignment lock");

	ready_rise_a: assert property (@(posedge clk) disable iff (rst)
		alignLock && !signalLoss && !softRxReset |=> rxPcsReady)
		else $error("ready not raised after lock");

	ready_in_reset_a: assert property (@(posedge clk) disable iff (rst)
		softRxReset |=> !rxPcsReady)
		else $error("ready high during soft reset");

	reset_load_a: assert property (@(posedge clk) disable iff (rst)
		lossRise |=> q.rstCnt == 4'(lse_pkg::RESET_CYC))
		else $error("soft reset count not loaded");

	reset_count_a: assert property (@(posedge clk) disable iff (rst)
		q.rstCnt != 4'h0 && !lossRise |=> q.rstCnt == $past(q.rstCnt) - 4'h1)
		else $error("soft reset count did not step");

	reset_end_a: assert property (@(posedge clk) disable iff (rst)
		softRxReset && q.rstCnt == 4'h1 && !lossRise |=> !softRxReset)
		else $error("soft reset too long");

	loss_event_a: assert property (@(posedge clk) disable iff (rst)
		lossRise |=> q.irqStat[lse_pkg::IRQ_LOS])
		else $error("loss event not latched");

	fault_clear_a: assert property (@(posedge clk) disable iff (rst)
		!signalLoss |=> !localFaultStatus)
		else $error("local fault without loss");

	fault_gen_off_a: assert property (@(posedge clk) disable iff (rst)
		!q.faultGen |=> !localFaultStatus)
		else $error("local fault while generation off");

	ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == lse_pkg::ADDR_CTRL |=> q.faultGen == $past(bus.wdata[lse_pkg::BIT_FAULTGEN]))
		else $error("fault enable not written");

	lock_read_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_LOCK |=>
		rdata[lse_pkg::LANES-1:0] == $past(laneClockLock) && rdata[31:lse_pkg::LANES] == '0)
		else $error("lane lock readback mismatch");

	clr_write_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == lse_pkg::ADDR_FRMCLR |=> q.frmClr == $past(bus.wdata[0]))
		else $error("framing clear not written");

	clr_read_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_FRMCLR |=> rdata[0] == $past(q.frmClr))
		else $error("framing clear readback mismatch");

	frm_clear_a: assert property (@(posedge clk) disable iff (rst)
		q.frmClr |=> q.frmErr == 32'h0)
		else $error("framing count not cleared");

	frm_count_a: assert property (@(posedge clk) disable iff (rst)
		!q.frmClr && !(&laneWordLock) && q.frmErr != 32'hffffffff |=> q.frmErr == $past(q.frmErr) + 32'h1)
		else $error("framing count did not grow");

	frm_hold_a: assert property (@(posedge clk) disable iff (rst)
		!q.frmClr && &laneWordLock |=> $stable(q.frmErr))
		else $error("framing count moved under lock");

	frm_read_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_FRMERR |=> rdata == $past(q.frmErr))
		else $error("framing count readback mismatch");

	flag_sel_wr_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == lse_pkg::ADDR_FLAGSEL |=> q.flagSel == $past(bus.wdata[7:0]))
		else $error("flag select not written");

	flag_sel_rd_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == lse_pkg::ADDR_FLAGSEL |=> rdata[7:0] == $past(q.flagSel))
		else $error("flag select readback mismatch");

	rx_full_a: assert property (@(posedge clk) disable iff (rst)
		rxFifoFlags[0] |=> q.irqStat[lse_pkg::IRQ_RXFULL])
		else $error("receive full not latched");

	tx_valid_a: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> txOut.valid == $past(txIn.valid))
		else $error("tx valid altered");

	tx_last_a: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> txOut.lastBeat == $past(txIn.lastBeat))
		else $error("tx last beat altered");

	tx_data_a: assert property (@(posedge clk) disable iff (rst)
		!(txIn.valid && txIn.lastBeat && txIn.abortReq) |=> txOut.block == $past(txIn.block))
		else $error("tx data overwritten without flag");

	crc_out_a: assert property (@(posedge clk) disable iff (rst)
		rxCrcBad && rxPcsReady |=> crcErrorOut)
		else $error("crc error not reported");

	crc_quiet_a: assert property (@(posedge clk) disable iff (rst)
		!rxCrcBad |=> !crcErrorOut)
		else $error("spurious crc error");

	crc_clear_a: assert property (@(posedge clk) disable iff (rst)
		!(rxCrcBad && rxPcsReady) && bus.wr && bus.addr == lse_pkg::ADDR_IRQCLR && bus.wdata[lse_pkg::IRQ_CRC]
		|=> !q.irqStat[lse_pkg::IRQ_CRC])
		else $error("crc event not cleared");

	fcs_out_a: assert property (@(posedge clk) disable iff (rst)
		rxPayloadBad && rxPcsReady |=> fcsErrorOut)
		else $error("fcs error not reported");

	fcs_quiet_a: assert property (@(posedge clk) disable iff (rst)
		!rxPayloadBad |=> !fcsErrorOut)
		else $error("spurious fcs error");

	dec_out_a: assert property (@(posedge clk) disable iff (rst)
		rxDecodeBad && rxPcsReady |=> decodeErrorOut)
		else $error("decode error not reported");

	dec_quiet_a: assert property (@(posedge clk) disable iff (rst)
		!rxDecodeBad |=> !decodeErrorOut)
		else $error("spurious decode error");

	lock_gate_a: assert property (@(posedge clk) disable iff (rst)
		!rxPcsReady |=> !crcErrorOut && !fcsErrorOut && !decodeErrorOut)
		else $error("error reported before lock");
endmodule : lse_link_status

/* tb/lse_client_model.sv */
// transmit client model feeding beats into the link status block
`timescale 1ns/100ps
module lse_client_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [65:0] data,
	input wire logic last,
	input wire logic abort,
	output lse_pkg::lse_tx_s txIn
);
	initial txIn = '0;
	// abort only with last beat
	// idle bus toggles so no stale beat is seen
	always @(posedge clk) begin
		txIn.valid <= go;
		txIn.lastBeat <= go & last;
		txIn.abortReq <= go & last & abort;
		txIn.block <= go ? data : ~txIn.block;
	end
endmodule : lse_client_model

/* tb/tb_top.sv */
// self-checking bench for the link status block
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, rst = 1, alignLock = 1, signalLoss = 0, go = 0, last = 0, abort = 0, rdSeen = 0;
	logic [2:0] errIn = '0;
	logic [3:0] wordLock = '1, clkLock = '1;
	logic [7:0] txF = '0, rxF = '0;
	logic [65:0] data = '0;
	logic [31:0] rdata, seed = 32'h1d75d7f7;
	logic ready, lfs, srr, crcO, fcsO, decO, irq;
	lse_pkg::lse_bus_s bus = '0;
	lse_pkg::lse_tx_s txIn, txOut;
	logic [65:0] txQ[$], rdQ[$];
	int err_total = 0, samples_checked = 0, srrCnt = 0;
	initial forever #2.5 clk = ~clk;
	lse_client_model i_client (.clk(clk), .go(go), .data(data), .last(last), .abort(abort), .txIn(txIn));
	lse_link_status i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .laneWordLock(wordLock),
		.laneClockLock(clkLock), .alignLock(alignLock), .signalLoss(signalLoss), .txFifoFlags(txF),
		.rxFifoFlags(rxF), .rxCrcBad(errIn[0]), .rxPayloadBad(errIn[1]), .rxDecodeBad(errIn[2]), .txIn(txIn),
		.txOut(txOut), .rxPcsReady(ready), .localFaultStatus(lfs), .softRxReset(srr), .crcErrorOut(crcO),
		.fcsErrorOut(fcsO), .decodeErrorOut(decO), .irq(irq));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(input logic [65:0] got, input logic [65:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task chkb(input logic got, input logic exp);
		chk({65'h0, got}, {65'h0, exp});
	endtask : chkb
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		rdQ.push_back({34'h0, e});
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask : rd
	task beat(input logic [1:0] m);
		logic [65:0] d;
		d = {rnd(), rnd(), 2'h1};
		@(posedge clk);
		go <= 1;
		data <= d;
		last <= m[0];
		abort <= m[1];
		txQ.push_back(&m ? lse_pkg::ERR_BLOCK : d);
	endtask : beat
	task idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : idle
	task print_verdict();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// results are compared against the oldest note when they appear
	always @(posedge clk) rdSeen <= bus.rd;
	always @(posedge clk) if (srr === 1'b1) srrCnt++;
	always @(negedge clk) if (rdSeen) chk({34'h0, rdata}, rdQ.pop_front());
	always @(negedge clk) if (txOut.valid === 1'b1) chk(txOut.block, txQ.pop_front());
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		txF <= 8'(rnd());
		rxF <= 8'(rnd()) & 8'hfe;
		clkLock <= 4'(rnd());
		wordLock <= 4'h5;
		rd(lse_pkg::ADDR_CTRL, 32'h1);
		rd(12'h3ff, 32'h0);
		rd(lse_pkg::ADDR_LOCK, {28'h0, clkLock});
		rd(lse_pkg::ADDR_LOCK, {28'h0, clkLock});
		wordLock <= '1;
		wr(lse_pkg::ADDR_FRMCLR, 32'h1);
		wr(lse_pkg::ADDR_FRMCLR, 32'h0);
		rd(lse_pkg::ADDR_FRMERR, 32'h0);
		wr(lse_pkg::ADDR_FLAGSEL, 32'h1);
		rd(lse_pkg::ADDR_FLAGS, {24'h0, txF});
		wr(lse_pkg::ADDR_FLAGSEL, 32'h0);
		rd(lse_pkg::ADDR_FLAGS, {24'h0, rxF});
		rd(lse_pkg::ADDR_ALIGN, 32'h1);
		rd(lse_pkg::ADDR_FAULT, 32'h0);
		wr(lse_pkg::ADDR_IRQEN, 32'h1);
		srrCnt = 0;
		signalLoss <= 1;
		beat(2'h3);
		repeat (20) beat(2'(rnd()));
		@(posedge clk) go <= 0;
		idle(4);
		chk(66'(srrCnt), 66'h8);
		chkb(ready, 1'b0);
		chkb(lfs, 1'b1);
		chkb(irq, 1'b1);
		rd(lse_pkg::ADDR_FAULT, 32'h1);
		rd(lse_pkg::ADDR_ALIGN, 32'h0);
		wr(lse_pkg::ADDR_IRQEN, 32'h0);
		idle(1);
		chkb(irq, 1'b0);
		wr(lse_pkg::ADDR_IRQEN, 32'h1);
		signalLoss <= 0;
		wr(lse_pkg::ADDR_IRQCLR, 32'h1);
		idle(12);
		chkb(irq, 1'b0);
		chkb(ready, 1'b1);
		wr(lse_pkg::ADDR_CTRL, 32'h0);
		signalLoss <= 1;
		idle(4);
		chkb(lfs, 1'b0);
		wr(lse_pkg::ADDR_CTRL, 32'h1);
		signalLoss <= 0;
		idle(14);
		// receive error pulses, one per kind
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) errIn <= 3'(1 << i);
			@(posedge clk) errIn <= 3'h0;
			@(negedge clk) chk({63'h0, decO, fcsO, crcO}, 66'(1 << i));
		end
		idle(2);
		chk(66'(txQ.size()), 66'h0);
		print_verdict();
	end
endmodule : tb_top
